// ---- rtl/uaf_pkg.sv ----
/*
  constants, field positions and state types for the autoflow
  and ready-signalling block of one serial channel.
  assumes a single 100 MHz clock and 8N1 character framing.
*/
package uaf_pkg;
  // clock and oversampling
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEF = 115_200;
  localparam int OS_RATE = 16;
  localparam int OS_DIV_DEF = CLK_HZ / (OS_RATE * BAUD_DEF);
  localparam logic [3:0] OS_HALF = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [2:0] DBIT_LAST = 3'h7;

  // control bit positions
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_AFE_BIT = 5;
  localparam int EFR_ARTS_BIT = 6;

  // queue sizing and trigger levels
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] TRIG_1 = 5'h01;
  localparam logic [LVL_W-1:0] TRIG_4 = 5'h04;
  localparam logic [LVL_W-1:0] TRIG_8 = 5'h08;
  localparam logic [LVL_W-1:0] TRIG_14 = 5'h0E;
  localparam logic [1:0] SEL_1 = 2'h0;
  localparam logic [1:0] SEL_4 = 2'h1;
  localparam logic [1:0] SEL_8 = 2'h2;
  localparam logic [1:0] SEL_14 = 2'h3;

  // receive timeout, counted in oversample ticks
  localparam int TMO_CHARS = 4;
  localparam int CHAR_BITS = 10;
  localparam int TMO_TICKS = TMO_CHARS * CHAR_BITS * OS_RATE;
  localparam int TMO_W = 10;

  // reset values
  localparam logic RTS_N_RST = 1'b1;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } uaf_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } uaf_rx_state_e;
endpackage : uaf_pkg

// ---- rtl/uaf_tick_div.sv ----
/*
  oversample enable divider: one-cycle pulse every DIV clocks.
  assumes DIV of at least two.
*/
`timescale 1ns/10ps
module uaf_tick_div #(
  parameter int DIV = 54
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : uaf_tick_div

// ---- rtl/uaf_fifo.sv ----
/*
  synchronous fifo with valid/ready on both sides and a fill level.
  assumes one clock; reads come straight from the storage array.
*/
`timescale 1ns/10ps
module uaf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level <= '0;
    end else if (push && !pop) begin
      level <= level + 1'b1;
    end else if (pop && !push) begin
      level <= level - 1'b1;
    end
  end
endmodule : uaf_fifo

// ---- rtl/uaf_autoflow.sv ----
/*
  one serial channel: 8N1 transmitter and receiver with auto-cts,
  auto-rts, active-low ready outputs and local loopback.
  assumes all inputs synchronous to ref_clk; the host side
  drives the control bytes and the two queue ports.
*/
`timescale 1ns/10ps
module uaf_autoflow
  import uaf_pkg::*;
#(
  parameter int OS_DIV = OS_DIV_DEF,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] modem_ctrl_reg,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic [1:0] rx_trig_sel,
  input wire logic [1:0] tx_trig_sel,
  input wire logic loopback,
  input wire logic [7:0] tx_wr_data,
  input wire logic tx_wr_valid,
  output logic tx_wr_ready,
  output logic [7:0] rx_rd_data,
  output logic rx_rd_err,
  output logic rx_rd_valid,
  input wire logic rx_rd_ready,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  output logic rx_ready_n,
  output logic tx_ready_n,
  output logic cts_delta,
  output logic [LVL_W-1:0] rx_level
);
  logic tick;
  logic mcr_rts;
  logic auto_cts_en;
  logic auto_rts_en;
  logic trig14;
  logic [LVL_W-1:0] rx_trig;
  logic [LVL_W-1:0] tx_trig;
  logic [LVL_W-1:0] tx_level;
  logic [LVL_W-1:0] tx_free;
  logic [7:0] tx_q_data;
  logic tx_q_valid;
  logic tx_take;
  logic cts_ok_now;
  logic cts_go;
  logic cts_q;
  uaf_tx_state_e tx_state;
  logic [3:0] tx_os;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_line;
  logic rx_in;
  uaf_rx_state_e rx_state;
  logic [3:0] rx_os;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_in_flight;
  logic rx_push;
  logic [8:0] rx_push_data;
  logic [8:0] rx_q_data;
  logic rx_q_ready;
  logic rx_pop;
  logic [LVL_W-1:0] err_cnt;
  logic [TMO_W-1:0] tmo_cnt;
  logic tmo_hit;
  logic rts_ok;
  logic rx_rdy;
  logic tx_rdy;

  uaf_tick_div #(.DIV(OS_DIV)) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // control decode
  assign mcr_rts = modem_ctrl_reg[MCR_RTS_BIT];
  assign auto_cts_en = modem_ctrl_reg[MCR_AFE_BIT];
  assign auto_rts_en = enhanced_feature_reg[EFR_ARTS_BIT] & mcr_rts;
  assign trig14 = (rx_trig_sel == SEL_14);

  function automatic logic [LVL_W-1:0] trig_of(input logic [1:0] sel);
    case (sel)
      SEL_1: trig_of = TRIG_1;
      SEL_4: trig_of = TRIG_4;
      SEL_8: trig_of = TRIG_8;
      default: trig_of = TRIG_14;
    endcase
  endfunction : trig_of

  assign rx_trig = trig_of(rx_trig_sel);
  assign tx_trig = trig_of(tx_trig_sel);
  assign tx_free = LVL_W'(DEPTH) - tx_level;

  ////////////////////////////////////////////////////////////////////
  // queues
  // sixteen-entry queues
  uaf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(tx_wr_data),
    .in_valid(tx_wr_valid),
    .in_ready(tx_wr_ready),
    .out_data(tx_q_data),
    .out_valid(tx_q_valid),
    .out_ready(tx_take),
    .level(tx_level)
  );

  uaf_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_rxq (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(rx_push_data),
    .in_valid(rx_push),
    .in_ready(rx_q_ready),
    .out_data(rx_q_data),
    .out_valid(rx_rd_valid),
    .out_ready(rx_rd_ready),
    .level(rx_level)
  );

  assign rx_rd_data = rx_q_data[7:0];
  assign rx_rd_err = rx_q_data[8];
  assign rx_pop = rx_rd_valid & rx_rd_ready;

  ////////////////////////////////////////////////////////////////////
  // transmitter
  // start only with cts while auto-cts is on
  assign cts_ok_now = !auto_cts_en || !cts_n;
  assign tx_take = tx_q_valid &&
    (((tx_state == TX_IDLE) && cts_ok_now) ||
     ((tx_state == TX_STOP) && tick && (tx_os == OS_LAST) && cts_go));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_os <= '0;
      tx_bit <= '0;
      tx_sh <= '0;
      tx_line <= LINE_IDLE;
    end else if (tx_take) begin
      tx_state <= TX_START;
      tx_os <= '0;
      tx_sh <= tx_q_data;
      tx_line <= 1'b0;
    end else if (tick && (tx_state != TX_IDLE)) begin
      tx_os <= tx_os + 1'b1;
      if (tx_os == OS_LAST) begin
        case (tx_state)
          TX_START: begin
            tx_state <= TX_DATA;
            tx_bit <= '0;
            tx_line <= tx_sh[0];
          end
          TX_DATA: begin
            tx_bit <= tx_bit + 1'b1;
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_line <= (tx_bit == DBIT_LAST) ? LINE_IDLE : tx_sh[1];
            if (tx_bit == DBIT_LAST) begin
              tx_state <= TX_STOP;
            end
          end
          default: begin
            tx_state <= TX_IDLE;
            tx_line <= LINE_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cts_go <= 1'b0;
    end else if (tick && (tx_state == TX_STOP) && (tx_os == OS_HALF)) begin
      cts_go <= cts_ok_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd <= LINE_IDLE;
    end else begin
      txd <= tx_line | loopback;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cts_q <= 1'b1;
      cts_delta <= 1'b0;
    end else begin
      cts_q <= cts_n;
      cts_delta <= (cts_n != cts_q) && !auto_cts_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver
  // transmit looped to receive
  assign rx_in = loopback ? tx_line : rxd;

  // overrun: a character that finds the queue full is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_os <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_in_flight <= 1'b0;
      rx_push <= 1'b0;
      rx_push_data <= '0;
    end else begin
      rx_push <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_os <= '0;
          if (!rx_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_os <= rx_os + 1'b1;
            if (rx_os == OS_HALF) begin
              rx_os <= '0;
              rx_bit <= '0;
              rx_state <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_os <= rx_os + 1'b1;
            if (rx_os == OS_LAST) begin
              rx_sh <= {rx_in, rx_sh[7:1]};
              rx_bit <= rx_bit + 1'b1;
              rx_in_flight <= 1'b1;
              if (rx_bit == DBIT_LAST) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        default: begin
          if (tick) begin
            rx_os <= rx_os + 1'b1;
            if (rx_os == OS_LAST) begin
              rx_push <= rx_q_ready;
              rx_push_data <= {~rx_in, rx_sh};
              rx_in_flight <= 1'b0;
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // entries in the queue carrying a framing error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_cnt <= '0;
    end else begin
      err_cnt <= err_cnt + LVL_W'(rx_push && rx_push_data[8])
                         - LVL_W'(rx_pop && rx_rd_err);
    end
  end

  // timeout: data waiting, no queue activity for four characters
  always_ff @(posedge ref_clk) begin
    if (rst || rx_push || rx_pop || (rx_level == '0)) begin
      tmo_cnt <= '0;
      tmo_hit <= 1'b0;
    end else if (tick && !tmo_hit) begin
      tmo_cnt <= tmo_cnt + 1'b1;
      tmo_hit <= (tmo_cnt == TMO_W'(TMO_TICKS - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ready outputs
  // empty or error wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_rdy <= 1'b0;
    end else if ((rx_level == '0) || (err_cnt != '0)) begin
      rx_rdy <= 1'b0;
    end else if ((rx_level >= rx_trig) || tmo_hit) begin
      rx_rdy <= 1'b1;
    end
  end
  assign rx_ready_n = ~rx_rdy;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_rdy <= 1'b0;
    end else if (tx_level == LVL_W'(DEPTH)) begin
      tx_rdy <= 1'b0;
    end else if (tx_free >= tx_trig) begin
      tx_rdy <= 1'b1;
    end
  end
  assign tx_ready_n = ~tx_rdy;

  ////////////////////////////////////////////////////////////////////
  // request-to-send
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rts_ok <= 1'b1;
    end else if (trig14) begin
      rts_ok <= (rx_level + LVL_W'(rx_in_flight)) < LVL_W'(DEPTH);
    end else if (rx_level >= rx_trig) begin
      rts_ok <= 1'b0;
    end else if (rx_level == '0) begin
      rts_ok <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rts_n <= RTS_N_RST;
    end else begin
      rts_n <= ~(mcr_rts && (!auto_rts_en || rts_ok));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_cts_drop;
    auto_cts_en && (tx_state == TX_STOP) && tick && (tx_os == OS_HALF)
      && cts_n;
  endsequence

  sequence s_stop_end;
    (tx_state == TX_STOP) && tick && (tx_os == OS_LAST);
  endsequence

  property p_rts_manual;
    !auto_rts_en |=> (rts_n == !$past(mcr_rts));
  endproperty
  a_rts_manual: assert property (p_rts_manual)
    else $error("rts pin does not follow manual bit");

  property p_rts_reset;
    disable iff (1'b0) rst |=> rts_n;
  endproperty
  a_rts_reset: assert property (p_rts_reset)
    else $error("rts not high after reset");

  property p_rx_ready_n_low;
    (rx_level >= rx_trig) && (err_cnt == '0) |=> !rx_ready_n;
  endproperty
  a_rx_ready_n_low: assert property (p_rx_ready_n_low)
    else $error("receive ready not low at trigger");

  property p_rx_ready_n_high;
    (rx_level == '0) || (err_cnt != '0) |=> rx_ready_n;
  endproperty
  a_rx_ready_n_high: assert property (p_rx_ready_n_high)
    else $error("receive ready not high on empty or error");

  property p_tx_ready_n_low;
    (tx_free >= tx_trig) |=> !tx_ready_n;
  endproperty
  a_tx_ready_n_low: assert property (p_tx_ready_n_low)
    else $error("transmit ready not low with space");

  property p_tx_ready_n_high;
    (tx_level == LVL_W'(DEPTH)) |=> tx_ready_n;
  endproperty
  a_tx_ready_n_high: assert property (p_tx_ready_n_high)
    else $error("transmit ready not high when full");

  property p_cts_gate;
    auto_cts_en && cts_n && (tx_state == TX_IDLE) |=> (tx_state == TX_IDLE);
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("byte started while cts inactive");

  // a late release clears the go flag
  property p_cts_withhold;
    s_cts_drop |=> !cts_go;
  endproperty
  a_cts_withhold: assert property (p_cts_withhold)
    else $error("go flag kept after late cts release");

  // without the go flag the stop bit ends the traffic
  property p_cts_hold;
    (auto_cts_en && !cts_go) ##0 s_stop_end |-> !tx_take;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("next byte started without cts at stop");

  property p_no_cts_evt;
    auto_cts_en |=> !cts_delta;
  endproperty
  a_no_cts_evt: assert property (p_no_cts_evt)
    else $error("cts change event under auto cts");

  property p_rts_drop;
    auto_rts_en && !trig14 && (rx_level >= rx_trig) |=> ##1 rts_n;
  endproperty
  a_rts_drop: assert property (p_rts_drop)
    else $error("rts not dropped at trigger level");

  property p_rts_raise;
    auto_rts_en && !trig14 && (rx_level == '0) && $stable(rx_level)
      |=> ##1 !rts_n;
  endproperty
  a_rts_raise: assert property (p_rts_raise)
    else $error("rts not raised after draining");
endmodule : uaf_autoflow

// ---- testbench/uaf_remote_uart.sv ----
/*
  remote serial party for the autoflow bench: an 8N1 sender on rxd
  that heeds rts_n at each byte start, and a receiver on txd.
  assumes a bit time of BIT_CLKS ref_clk cycles; the line idles high.
*/
`timescale 1ns/10ps
module uaf_remote_uart #(
  parameter int BIT_CLKS = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic send_en,
  input wire logic [7:0] send_data,
  output logic rxd,
  output logic sent_stb,
  output logic [7:0] got_data,
  output logic got_stb
);
  ////////////////////////////////////////////////////////////////////
  // sender: one-cycle sent_stb when a byte starts
  initial begin
    logic [9:0] frame;
    rxd = 1'b1;
    sent_stb = 1'b0;
    forever begin
      @(posedge ref_clk);
      // rts looked at only at byte start
      if (!rst && send_en && rts_n === 1'b0) begin
        frame = {1'b1, send_data, 1'b0};
        sent_stb <= 1'b1;
        for (int i = 0; i < 10; i++) begin
          rxd <= frame[i];
          @(posedge ref_clk);
          sent_stb <= 1'b0;
          repeat (BIT_CLKS - 1) @(posedge ref_clk);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver: samples mid-bit, pulses got_stb at stop midpoint
  initial begin
    got_stb = 1'b0;
    got_data = 8'h00;
    forever begin
      @(posedge ref_clk);
      got_stb <= 1'b0;
      if (!rst && txd === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge ref_clk);
          got_data[i] <= txd;
        end
        repeat (BIT_CLKS) @(posedge ref_clk);
        got_stb <= 1'b1;
      end
    end
  end
endmodule : uaf_remote_uart

// ---- testbench/uaf_autoflow_test.sv ----
/*
  self-checking bench for uaf_autoflow with a remote serial party.
  assumes OS_DIV of 4, so one bit is 64 clocks and a byte 640.
*/
`timescale 1ns/10ps
module uaf_autoflow_test
  import uaf_pkg::*;
;
  logic ref_clk, rst, loopback, tx_wr_valid, tx_wr_ready, rx_rd_err;
  logic rx_rd_valid, rx_rd_ready, rxd, txd, cts_n, rts_n, rx_ready_n;
  logic tx_ready_n, cts_delta, send_en, sent_stb, got_stb;
  logic [7:0] modem_ctrl_reg, enhanced_feature_reg, tx_wr_data;
  logic [7:0] rx_rd_data, send_data, got_data;
  logic [1:0] rx_trig_sel, tx_trig_sel;
  logic [LVL_W-1:0] rx_level;
  logic [LVL_W-1:0] trig [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
  logic [7:0] tx_exp [$];
  logic [7:0] rx_exp [$];
  int num_errors = 0, n_compared = 0, n_delta = 0, seed = 57;

  uaf_autoflow #(.OS_DIV(4), .DEPTH(FIFO_DEPTH)) i_uaf_autoflow (
    .ref_clk(ref_clk), .rst(rst), .modem_ctrl_reg(modem_ctrl_reg),
    .enhanced_feature_reg(enhanced_feature_reg),
    .rx_trig_sel(rx_trig_sel), .tx_trig_sel(tx_trig_sel),
    .loopback(loopback), .tx_wr_data(tx_wr_data),
    .tx_wr_valid(tx_wr_valid), .tx_wr_ready(tx_wr_ready),
    .rx_rd_data(rx_rd_data), .rx_rd_err(rx_rd_err),
    .rx_rd_valid(rx_rd_valid), .rx_rd_ready(rx_rd_ready), .rxd(rxd),
    .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .rx_ready_n(rx_ready_n),
    .tx_ready_n(tx_ready_n), .cts_delta(cts_delta), .rx_level(rx_level));

  uaf_remote_uart #(.BIT_CLKS(64)) i_uaf_remote_uart (
    .ref_clk(ref_clk), .rst(rst), .txd(txd), .rts_n(rts_n),
    .send_en(send_en), .send_data(send_data), .rxd(rxd),
    .sent_stb(sent_stb), .got_data(got_data), .got_stb(got_stb));

  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check_bit(input string what, input logic seen,
                           input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask : check_bit

  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // held until taken; a gap cycle between writes
  task automatic send_byte(input logic [7:0] b, input bit to_rx);
    @(posedge ref_clk);
    tx_wr_data <= b;
    tx_wr_valid <= 1'b1;
    do @(posedge ref_clk); while (tx_wr_ready !== 1'b1);
    tx_wr_valid <= 1'b0;
    if (to_rx) rx_exp.push_back(b);
    else tx_exp.push_back(b);
  endtask : send_byte

  task automatic drain();
    rx_rd_ready <= 1'b1;
    for (int k = 0; k < 40 && rx_rd_valid === 1'b1; k++) idle(1);
    rx_rd_ready <= 1'b0;
    idle(4);
  endtask : drain

  ////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each result seen
  // falling edge, so every output has settled
  always @(negedge ref_clk) begin
    if (cts_delta === 1'b1) n_delta++;
    if (got_stb === 1'b1) begin
      if (tx_exp.size() == 0) check_bit("txd extra byte", 1'b1, 1'b0);
      else check("txd byte", got_data, tx_exp.pop_front());
    end
    if (sent_stb === 1'b1) begin
      rx_exp.push_back(send_data);
      send_data <= 8'($random(seed));
    end
    if (rx_rd_valid === 1'b1 && rx_rd_ready === 1'b1) begin
      if (rx_exp.size() == 0) check_bit("rx extra byte", 1'b1, 1'b0);
      else check("rx byte", rx_rd_data, rx_exp.pop_front());
      check_bit("rx error flag", rx_rd_err, 1'b0);
    end
  end

  initial begin
    #800_000;
    num_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    modem_ctrl_reg = 8'h00;
    enhanced_feature_reg = 8'h00;
    rx_trig_sel = SEL_1;
    tx_trig_sel = SEL_4;
    loopback = 1'b0;
    tx_wr_data = 8'h00;
    tx_wr_valid = 1'b0;
    rx_rd_ready = 1'b0;
    cts_n = 1'b1;
    send_en = 1'b0;
    send_data = 8'hA5;
    idle(16);
    check_bit("rts_n in reset", rts_n, 1'b1);
    rst <= 1'b0;
    idle(3);
    check_bit("tx_ready_n empty", tx_ready_n, 1'b0);
    modem_ctrl_reg <= 8'h02;
    idle(3);
    check_bit("rts_n manual on", rts_n, 1'b0);
    modem_ctrl_reg <= 8'h00;
    idle(3);
    check_bit("rts_n manual off", rts_n, 1'b1);
    // cts inactive but auto-cts off: everything goes out
    for (int i = 0; i < 3; i++) send_byte(8'($random(seed)), 1'b0);
    idle(2200);
    check("tx left", 8'(tx_exp.size()), 8'h00);
    // auto-cts holds a full queue; one refused write
    // cts only, bit1 clear
    modem_ctrl_reg <= 8'h20;
    for (int i = 0; i < FIFO_DEPTH; i++) send_byte(8'($random(seed)), 1'b0);
    tx_wr_data <= 8'h3C;
    tx_wr_valid <= 1'b1;
    idle(1000);
    check_bit("tx_wr_ready full", tx_wr_ready, 1'b0);
    check_bit("tx_ready_n full", tx_ready_n, 1'b1);
    check("tx held", 8'(tx_exp.size()), 8'(FIFO_DEPTH));
    tx_wr_valid <= 1'b0;
    n_delta = 0;
    cts_n <= 1'b0;
    idle(10600);
    check("tx drained", 8'(tx_exp.size()), 8'h00);
    check("cts events auto", 8'(n_delta), 8'h00);
    check_bit("tx_ready_n space", tx_ready_n, 1'b0);
    send_byte(8'($random(seed)), 1'b0);
    send_byte(8'($random(seed)), 1'b0);
    idle(300);
    cts_n <= 1'b1;
    idle(1200);
    check("tx withheld", 8'(tx_exp.size()), 8'h01);
    cts_n <= 1'b0;
    idle(800);
    check("tx resumed", 8'(tx_exp.size()), 8'h00);
    modem_ctrl_reg <= 8'h00;
    idle(2);
    cts_n <= 1'b1;
    idle(4);
    check("cts events manual", 8'(n_delta), 8'h01);
    // auto-rts over every receive trigger level
    // full autoflow enable
    modem_ctrl_reg <= 8'h22;
    enhanced_feature_reg <= 8'h40;
    for (int s = 0; s < 4; s++) begin
      rx_trig_sel <= 2'(s);
      idle(4);
      check_bit("rts_n room", rts_n, 1'b0);
      send_en <= 1'b1;
      for (int k = 0; k < 12000 && rts_n !== 1'b1; k++) idle(1);
      send_en <= 1'b0;
      idle(1400);
      check_bit("rts_n at trigger", rts_n, 1'b1);
      check_bit("level reached", rx_level >= trig[s], 1'b1);
      check_bit("rx_ready_n trigger", rx_ready_n, 1'b0);
      drain();
      check("rx left", 8'(rx_exp.size()), 8'h00);
      check_bit("rts_n emptied", rts_n, 1'b0);
      check_bit("rx_ready_n empty", rx_ready_n, 1'b1);
    end
    // receive timeout below the trigger level
    rx_trig_sel <= SEL_4;
    send_en <= 1'b1;
    idle(2);
    send_en <= 1'b0;
    idle(700);
    check_bit("rx_ready_n below trigger", rx_ready_n, 1'b1);
    idle(2700);
    check_bit("rx_ready_n timeout", rx_ready_n, 1'b0);
    drain();
    // loopback: transmit data comes back to the receiver
    // auto-cts is still on, so cts must be active here
    cts_n <= 1'b0;
    loopback <= 1'b1;
    send_byte(8'($random(seed)), 1'b1);
    idle(900);
    check("loopback level", 8'(rx_level), 8'h01);
    drain();
    complete_run();
  end
endmodule : uaf_autoflow_test
